// >>> rtl/pfr_params.svh
`ifndef PFR_PARAMS_SVH
`define PFR_PARAMS_SVH

// Register offsets
`define PFR_OFS_SIGNAL_STATUS 6'h06
`define PFR_OFS_EXT_RX_CTRL 6'h17
`define PFR_OFS_SHORT_LO 6'h20
`define PFR_OFS_SHORT_HI 6'h21
`define PFR_OFS_NETID_LO 6'h22
`define PFR_OFS_NETID_HI 6'h23
`define PFR_OFS_EXT_ADDR0 6'h24
`define PFR_OFS_EXT_ADDR7 6'h2b
`define PFR_OFS_ACK_CTRL 6'h2e

// Field positions
`define PFR_BIT_FCS_VALID 7
`define PFR_BIT_PROM_EN 1
`define PFR_BIT_ACK_DIS 4
`define PFR_FVN_HI 7
`define PFR_FVN_LO 6
`define PFR_LEVEL_HI 4
`define PFR_LEVEL_LO 0
`define PFR_FCF_TYPE_HI 2
`define PFR_FCF_TYPE_LO 0
`define PFR_FCF_ACKREQ 5
`define PFR_FCF_DST_HI 3
`define PFR_FCF_DST_LO 2
`define PFR_FCF_VER_HI 5
`define PFR_FCF_VER_LO 4

// Reset values
`define PFR_RST_EXT_RX_CTRL 8'h00
`define PFR_RST_ACK_CTRL 8'h00
`define PFR_RST_SHORT 16'hffff
`define PFR_RST_NETID 16'hffff
`define PFR_RST_EXT_ADDR 64'h0000_0000_0000_0000

// Frame layout
`define PFR_BROADCAST 16'hffff
`define PFR_IDX_FCF_LO 7'h00
`define PFR_IDX_FCF_HI 7'h01
`define PFR_IDX_PAN_LO 7'h03
`define PFR_IDX_PAN_HI 7'h04
`define PFR_IDX_DST0 7'h05
`define PFR_LEN_NO_DST 7'h03
`define PFR_LEN_SHORT_DST 7'h07
`define PFR_LEN_EXT_DST 7'h0d
`define PFR_CNT_MAX 7'h7f
`define PFR_TYPE_BEACON 3'h0
`define PFR_TYPE_DATA 3'h1
`define PFR_TYPE_CMD 3'h3
`define PFR_MODE_NONE 2'h0
`define PFR_MODE_SHORT 2'h2
`define PFR_MODE_EXT 2'h3
`define PFR_FVN_ANY 2'h3

`endif

// >>> rtl/pfr_pkg.sv
`default_nettype none
package pfr_pkg;
   // Receive sequencing
   typedef enum logic [0:0] {PFR_IDLE, PFR_RECV} pfr_rx_state_t;
   typedef logic [7:0] pfr_byte_t;
endpackage
`default_nettype wire

// >>> rtl/pfr_addr_filter.sv
`timescale 1ns/1ns
`default_nettype none
`include "pfr_params.svh"
module pfr_addr_filter
   import pfr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic byte_valid,
   input wire pfr_byte_t byte_data,
   input wire logic [15:0] my_short,
   input wire logic [15:0] my_net_id,
   input wire logic [63:0] my_ext,
   output logic addr_match,
   output logic ack_requested,
   output logic [1:0] frame_version
);
   logic [6:0] cnt_ff;
   pfr_byte_t fcf_lo_ff;
   pfr_byte_t fcf_hi_ff;
   logic [15:0] pan_ff;
   pfr_byte_t dst_ff [0:7];
   logic [2:0] ftype;
   logic [1:0] dst_mode;
   logic [15:0] dst_short;
   logic [63:0] dst_ext;
   logic [6:0] need_len;
   logic pan_ok;

   // Byte position, saturating so long frames never wrap into header slots
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_ff <= 7'h00;
      else if (clear)
         cnt_ff <= 7'h00;
      else if (byte_valid && cnt_ff != `PFR_CNT_MAX)
         cnt_ff <= cnt_ff + 7'h01;
   end

   // Capture header fields as they stream past
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fcf_lo_ff <= 8'h00;
         fcf_hi_ff <= 8'h00;
         pan_ff <= 16'h0000;
         for (int i = 0; i < 8; i++)
            dst_ff[i] <= 8'h00;
      end
      else if (clear)
      begin
         fcf_lo_ff <= 8'h00;
         fcf_hi_ff <= 8'h00;
      end
      else if (byte_valid)
      begin
         if (cnt_ff == `PFR_IDX_FCF_LO)
            fcf_lo_ff <= byte_data;
         if (cnt_ff == `PFR_IDX_FCF_HI)
            fcf_hi_ff <= byte_data;
         if (cnt_ff == `PFR_IDX_PAN_LO)
            pan_ff[7:0] <= byte_data;
         if (cnt_ff == `PFR_IDX_PAN_HI)
            pan_ff[15:8] <= byte_data;
         if (cnt_ff >= `PFR_IDX_DST0 && cnt_ff < `PFR_LEN_EXT_DST)
            dst_ff[3'(cnt_ff - `PFR_IDX_DST0)] <= byte_data;
      end
   end

   // Field decode
   assign ftype = fcf_lo_ff[`PFR_FCF_TYPE_HI:`PFR_FCF_TYPE_LO];
   assign ack_requested = fcf_lo_ff[`PFR_FCF_ACKREQ];
   assign dst_mode = fcf_hi_ff[`PFR_FCF_DST_HI:`PFR_FCF_DST_LO];
   assign frame_version = fcf_hi_ff[`PFR_FCF_VER_HI:`PFR_FCF_VER_LO];
   assign dst_short = {dst_ff[1], dst_ff[0]};
   assign dst_ext = {dst_ff[7], dst_ff[6], dst_ff[5], dst_ff[4],
                     dst_ff[3], dst_ff[2], dst_ff[1], dst_ff[0]};
   assign pan_ok = (pan_ff == my_net_id) || (pan_ff == `PFR_BROADCAST);

   // Address check; a truncated header never matches
   always_comb
   begin
      addr_match = 1'b0;
      need_len = `PFR_LEN_NO_DST;
      if (ftype == `PFR_TYPE_BEACON || ftype == `PFR_TYPE_DATA || ftype == `PFR_TYPE_CMD)
      begin
         case (dst_mode)
            `PFR_MODE_SHORT:
            begin
               need_len = `PFR_LEN_SHORT_DST;
               addr_match = pan_ok && (dst_short == my_short || dst_short == `PFR_BROADCAST);
            end
            `PFR_MODE_EXT:
            begin
               need_len = `PFR_LEN_EXT_DST;
               addr_match = pan_ok && (dst_ext == my_ext);
            end
            `PFR_MODE_NONE:
               addr_match = (ftype == `PFR_TYPE_BEACON);
            default:
               addr_match = 1'b0;
         endcase
         if (cnt_ff < need_len)
            addr_match = 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/pfr_rx_frame_filter.sv
// How it works
// (R1) Promiscuous: only FCS-level filtering, frames passed on without further MAC handling.
// (R2) Promiscuous: frame-end event for every frame, even with bad FCS.
// (R3) Host reads FCS-valid bit at 0x06 after frame end, drops bad frames.
// (R4) FCS result also shown in bit 7 of the receive status byte.
// (R5) Ack disable clear: valid, address-matched frames get acked, promiscuous too.
// (R6) Ack disable at 0x2E bit 4 kills all auto acks; host sets it.
// (R7) Bit 1 at 0x17 enables promiscuous reception in extended receive mode.
// (R8) Address-match event in every mode when frame matches node addresses.
// (R9) Basic receive: start event on header, end event when frame completes.
// (R10) FCS-valid bit updates in the same cycle as the frame-end event.
// (R11) Version select 7:6 gates acks: 00 v0, 01 v0-1, 10 v0-2, 11 any.
// (R12) Host zeroes all address registers for promiscuous setup.
// (R13) Sniffer: start and end events for every frame regardless of FCS.
// (R14) Host leaves other extended receive bits at reset for sniffer setup.
// (R15) Ack disable set: no ack starts, whatever the ack request bit says.
`timescale 1ns/1ns
`default_nettype none
`include "pfr_params.svh"
module pfr_rx_frame_filter
   import pfr_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST_B,
   // Register port
   input wire logic [5:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   // Receive side
   input wire logic RX_EXT_MODE,
   input wire logic RX_PHR_VALID,
   input wire logic RX_BYTE_VALID,
   input wire logic [7:0] RX_BYTE,
   input wire logic RX_FRAME_DONE,
   input wire logic RX_FCS_OK,
   input wire logic [4:0] RX_SIGNAL_LEVEL,
   // Events and status
   output logic FRAME_START_IRQ,
   output logic FRAME_END_IRQ,
   output logic ADDRESS_MATCH_IRQ,
   output logic ACK_START,
   output logic [7:0] RX_STATUS_BYTE
);

   // Reset release stages
   logic rst_meta_ff;
   logic rst_sync_ff;
   logic rst_n;
   // Software-visible registers
   logic [7:0] ext_rx_ctrl_ff;
   logic [7:0] ack_ctrl_ff;
   logic [15:0] short_addr_ff;
   logic [15:0] net_id_ff;
   logic [63:0] ext_addr_ff;
   logic fcs_valid_ff;
   logic [7:0] rdata_ff;
   // Registered event outputs
   logic start_irq_ff;
   logic end_irq_ff;
   logic match_irq_ff;
   logic ack_start_ff;
   // Receive sequencing
   pfr_rx_state_t state_ff;
   pfr_rx_state_t nxt_state;
   // Decoded controls
   logic prom_en;
   logic ack_dis;
   logic [1:0] fvn_sel;
   // Header filter results
   logic addr_match;
   logic ack_requested;
   logic [1:0] frame_version;
   logic version_ok;
   // Completion and register helpers
   logic frame_done;
   logic [2:0] ext_idx;
   logic [7:0] signal_status;

   // Reset release through two stages so deassertion is clean to CLK_SYS
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   assign rst_n = rst_sync_ff;

   // Control fields
   assign prom_en = ext_rx_ctrl_ff[`PFR_BIT_PROM_EN]; // (R7)
   assign ack_dis = ack_ctrl_ff[`PFR_BIT_ACK_DIS]; // (R6)
   assign fvn_sel = ack_ctrl_ff[`PFR_FVN_HI:`PFR_FVN_LO];
   assign ext_idx = 3'(REG_ADDR - `PFR_OFS_EXT_ADDR0);

   // Control registers; unused bits are kept so software reads back what it wrote
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_rx_ctrl_ff <= `PFR_RST_EXT_RX_CTRL;
         ack_ctrl_ff <= `PFR_RST_ACK_CTRL;
      end
      else if (REG_WR)
      begin
         if (REG_ADDR == `PFR_OFS_EXT_RX_CTRL)
            ext_rx_ctrl_ff <= REG_WDATA; // (R7)
         if (REG_ADDR == `PFR_OFS_ACK_CTRL)
            ack_ctrl_ff <= REG_WDATA; // (R6)
      end
   end

   // Node address registers; promiscuous setups zero them
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         short_addr_ff <= `PFR_RST_SHORT;
         net_id_ff <= `PFR_RST_NETID;
         ext_addr_ff <= `PFR_RST_EXT_ADDR;
      end
      else if (REG_WR)
      begin
         case (REG_ADDR)
            `PFR_OFS_SHORT_LO:
               short_addr_ff[7:0] <= REG_WDATA;
            `PFR_OFS_SHORT_HI:
               short_addr_ff[15:8] <= REG_WDATA;
            `PFR_OFS_NETID_LO:
               net_id_ff[7:0] <= REG_WDATA;
            `PFR_OFS_NETID_HI:
               net_id_ff[15:8] <= REG_WDATA;
            default:
            begin
               if (REG_ADDR >= `PFR_OFS_EXT_ADDR0 && REG_ADDR <= `PFR_OFS_EXT_ADDR7)
                  ext_addr_ff[8*ext_idx +: 8] <= REG_WDATA;
            end
         endcase
      end
   end

   // Status register view: FCS flag on top, level in the low bits
   always_comb
   begin
      signal_status = 8'h00;
      signal_status[`PFR_BIT_FCS_VALID] = fcs_valid_ff; // (R3)
      signal_status[`PFR_LEVEL_HI:`PFR_LEVEL_LO] = RX_SIGNAL_LEVEL;
   end

   // Read data registered one cycle after REG_RD; unmapped offsets read zero
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
         rdata_ff <= 8'h00;
      else if (REG_RD)
      begin
         case (REG_ADDR)
            `PFR_OFS_SIGNAL_STATUS:
               rdata_ff <= signal_status;
            `PFR_OFS_EXT_RX_CTRL:
               rdata_ff <= ext_rx_ctrl_ff;
            `PFR_OFS_ACK_CTRL:
               rdata_ff <= ack_ctrl_ff;
            `PFR_OFS_SHORT_LO:
               rdata_ff <= short_addr_ff[7:0];
            `PFR_OFS_SHORT_HI:
               rdata_ff <= short_addr_ff[15:8];
            `PFR_OFS_NETID_LO:
               rdata_ff <= net_id_ff[7:0];
            `PFR_OFS_NETID_HI:
               rdata_ff <= net_id_ff[15:8];
            default:
            begin
               if (REG_ADDR >= `PFR_OFS_EXT_ADDR0 && REG_ADDR <= `PFR_OFS_EXT_ADDR7)
                  rdata_ff <= ext_addr_ff[8*ext_idx +: 8];
               else
                  rdata_ff <= 8'h00;
            end
         endcase
      end
   end
   assign REG_RDATA = rdata_ff;

   // Header parsing and address comparison
   pfr_addr_filter u_addr_filter (
      .clk(CLK_SYS),
      .rst_n(rst_n),
      .clear(RX_PHR_VALID),
      .byte_valid(RX_BYTE_VALID),
      .byte_data(RX_BYTE),
      .my_short(short_addr_ff),
      .my_net_id(net_id_ff),
      .my_ext(ext_addr_ff),
      .addr_match(addr_match),
      .ack_requested(ack_requested),
      .frame_version(frame_version)
   );

   // Version gate: any version up to and including the limit, or everything at the top setting
   assign version_ok = (fvn_sel == `PFR_FVN_ANY) || (frame_version <= fvn_sel); // (R11)

   // Receive sequencing; a new header restarts a frame in flight
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         PFR_IDLE:
         begin
            if (RX_PHR_VALID)
               nxt_state = PFR_RECV;
         end
         PFR_RECV:
         begin
            if (RX_FRAME_DONE && !RX_PHR_VALID)
               nxt_state = PFR_IDLE;
         end
         default:
            nxt_state = PFR_IDLE;
      endcase
   end

   // State register; restarts are resolved in the next-state logic
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
         state_ff <= PFR_IDLE;
      else
         state_ff <= nxt_state;
   end

   // Completion only counts inside a frame, so stray done strobes are ignored
   assign frame_done = (state_ff == PFR_RECV) && RX_FRAME_DONE && !RX_PHR_VALID;

   // Start event on a valid header in basic and promiscuous receive
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
         start_irq_ff <= 1'b0;
      else
         start_irq_ff <= RX_PHR_VALID && (!RX_EXT_MODE || prom_en); // (R9) (R13)
   end

   // End event: every frame unless extended filtering rejects it
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
         end_irq_ff <= 1'b0;
      else if (frame_done)
      begin
         if (!RX_EXT_MODE)
            end_irq_ff <= 1'b1; // (R9)
         else if (prom_en)
            end_irq_ff <= 1'b1; // (R1) (R2) (R13)
         else
            end_irq_ff <= RX_FCS_OK && addr_match;
      end
      else
         end_irq_ff <= 1'b0;
   end

   // FCS flag loads on the same edge that raises the end event
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
         fcs_valid_ff <= 1'b0;
      else if (frame_done)
         fcs_valid_ff <= RX_FCS_OK; // (R10)
   end

   // Status byte mirrors the flag so the host can skip a register read
   assign RX_STATUS_BYTE = {fcs_valid_ff, 7'h00}; // (R4)

   // Address match reported in any mode, only for intact frames
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
         match_irq_ff <= 1'b0;
      else
         match_irq_ff <= frame_done && RX_FCS_OK && addr_match; // (R8)
   end

   // Ack only in extended receive, and never once ack disable is set
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
         ack_start_ff <= 1'b0;
      else
         ack_start_ff <= frame_done && RX_EXT_MODE && !ack_dis // (R6) (R15)
                         && RX_FCS_OK && addr_match && ack_requested && version_ok; // (R5) (R11)
   end

   // Event outputs are single-cycle pulses
   assign FRAME_START_IRQ = start_irq_ff;
   assign FRAME_END_IRQ = end_irq_ff;
   assign ADDRESS_MATCH_IRQ = match_irq_ff;
   assign ACK_START = ack_start_ff;
endmodule
`default_nettype wire

// >>> bench/pfr_rx_frame_filter_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module pfr_rx_frame_filter_monitor
(
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic [5:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic RX_EXT_MODE,
   input wire logic RX_PHR_VALID,
   input wire logic RX_FRAME_DONE,
   input wire logic RX_FCS_OK,
   input wire logic FRAME_START_IRQ,
   input wire logic FRAME_END_IRQ,
   input wire logic ADDRESS_MATCH_IRQ,
   input wire logic ACK_START,
   input wire logic [7:0] RX_STATUS_BYTE
);
   logic in_frame_ff;
   logic prom_ff;
   logic ack_dis_ff;

   // Mode bits shadowed from the register port, since they are not visible as pins
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         prom_ff <= 1'b0;
         ack_dis_ff <= 1'b0;
      end
      else if (REG_WR && REG_ADDR == 6'h17)
         prom_ff <= REG_WDATA[1];
      else if (REG_WR && REG_ADDR == 6'h2e)
         ack_dis_ff <= REG_WDATA[4];
   end

   // Frame window; a done pulse with a new header restarts instead
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         in_frame_ff <= 1'b0;
      else if (RX_PHR_VALID)
         in_frame_ff <= 1'b1;
      else if (RX_FRAME_DONE)
         in_frame_ff <= 1'b0;
   end

   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);

   sequence s_done;
      in_frame_ff && RX_FRAME_DONE && !RX_PHR_VALID;
   endsequence

   property p_start_irq;
      RX_PHR_VALID && (!RX_EXT_MODE || prom_ff) |=> FRAME_START_IRQ;
   endproperty
   property p_no_start_ext;
      RX_PHR_VALID && RX_EXT_MODE && !prom_ff |=> !FRAME_START_IRQ;
   endproperty
   property p_end_every;
      s_done ##0 (!RX_EXT_MODE || prom_ff) |=> FRAME_END_IRQ;
   endproperty
   property p_end_cause;
      FRAME_END_IRQ |-> $past(RX_FRAME_DONE);
   endproperty
   property p_fcs_flag;
      s_done |=> RX_STATUS_BYTE[7] == $past(RX_FCS_OK);
   endproperty
   property p_flag_hold;
      !$past(RX_FRAME_DONE) |-> $stable(RX_STATUS_BYTE);
   endproperty
   property p_match_fcs;
      ADDRESS_MATCH_IRQ |-> $past(RX_FCS_OK) && FRAME_END_IRQ;
   endproperty
   property p_ack_gate;
      ACK_START |-> $past(RX_EXT_MODE) && !$past(ack_dis_ff) && $past(RX_FCS_OK);
   endproperty
   property p_ack_match;
      ACK_START |-> ADDRESS_MATCH_IRQ;
   endproperty

   a_start_irq: assert property (p_start_irq) else $error("start event missing");
   a_no_start_ext: assert property (p_no_start_ext) else $error("start event in filtered mode");
   a_end_every: assert property (p_end_every) else $error("frame end event missing");
   a_end_cause: assert property (p_end_cause) else $error("frame end without done");
   a_fcs_flag: assert property (p_fcs_flag) else $error("fcs flag wrong");
   a_flag_hold: assert property (p_flag_hold) else $error("fcs flag moved");
   a_match_fcs: assert property (p_match_fcs) else $error("match event on bad fcs");
   a_ack_gate: assert property (p_ack_gate) else $error("ack while disabled");
   a_ack_match: assert property (p_ack_match) else $error("ack without match");
endmodule
`default_nettype wire

// >>> bench/pfr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module pfr_host_model
(
   input wire logic CLK_SYS,
   output logic [5:0] REG_ADDR,
   output logic [7:0] REG_WDATA,
   output logic REG_WR,
   output logic REG_RD,
   input wire logic [7:0] REG_RDATA
);
   // Idle bus at time zero
   initial
   begin
      REG_ADDR = 6'h00;
      REG_WDATA = 8'h00;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
   end

   // One strobe per access; data is inverted after release so nothing stale lingers
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1'b1;
      @(posedge CLK_SYS);
      #1;
      REG_WR = 1'b0;
      REG_WDATA = ~d;
      // Idle edge, so a following access never re-raises the strobe in this step
      @(posedge CLK_SYS);
      #1;
   endtask

   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      REG_ADDR = a;
      REG_RD = 1'b1;
      @(posedge CLK_SYS);
      #1;
      REG_RD = 1'b0;
      @(posedge CLK_SYS);
      #1;
      d = REG_RDATA;
   endtask

   // Promiscuous setup clears every address byte
   task automatic zero_addresses;
      for (int a = 'h20; a <= 'h2b; a++)
         wr(6'(a), 8'h00);
   endtask

   // Status poll after each frame end, to drop corrupt frames
   task automatic read_status(output logic [7:0] d);
      rd(6'h06, d);
   endtask
endmodule
`default_nettype wire

// >>> bench/promiscuous_rx_frame_filter_bench.sv
`timescale 1ns/1ns
`default_nettype none
module promiscuous_rx_frame_filter_bench;
   logic CLK_SYS, RST_B, REG_WR, REG_RD, RX_EXT_MODE, RX_PHR_VALID, RX_BYTE_VALID;
   logic RX_FRAME_DONE, RX_FCS_OK, FRAME_START_IRQ, FRAME_END_IRQ, ADDRESS_MATCH_IRQ, ACK_START;
   logic [5:0] REG_ADDR;
   logic [7:0] REG_WDATA, REG_RDATA, RX_BYTE, RX_STATUS_BYTE, d;
   logic [4:0] RX_SIGNAL_LEVEL;
   logic [15:0] my_short, my_net;
   logic [63:0] my_ext;
   int n_fail, samples_checked, seed, k;

   pfr_rx_frame_filter pfr_rx_frame_filter_i (.CLK_SYS, .RST_B, .REG_ADDR, .REG_WDATA,
      .REG_WR, .REG_RD, .REG_RDATA, .RX_EXT_MODE, .RX_PHR_VALID, .RX_BYTE_VALID, .RX_BYTE,
      .RX_FRAME_DONE, .RX_FCS_OK, .RX_SIGNAL_LEVEL, .FRAME_START_IRQ, .FRAME_END_IRQ,
      .ADDRESS_MATCH_IRQ, .ACK_START, .RX_STATUS_BYTE);
   pfr_host_model pfr_host_model_i (.CLK_SYS, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
      .REG_RDATA);

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic step;
      @(posedge CLK_SYS);
      #1;
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // One data frame, short or extended destination, checked against the reference decisions
   task automatic frame(input int ext, prom, dis, fvn, ver, req, fcs, pan, adr, xd);
      logic [7:0] b [13];
      logic [63:0] dst;
      int m;
      int n;
      dst = xd ? (adr == my_short ? my_ext : my_ext ^ 64'h1) : 64'(adr[15:0]);
      b[0] = {2'b00, req[0], 5'h01};
      b[1] = {2'b00, ver[1:0], xd ? 4'hc : 4'h8};
      b[2] = 8'h5a;
      b[3] = pan[7:0];
      b[4] = pan[15:8];
      for (int i = 0; i < 8; i++)
         b[5 + i] = dst[8*i +: 8];
      n = xd ? 13 : 7;
      m = (pan == my_net || pan == 'hffff) && (adr == my_short || (!xd && adr == 'hffff));
      pfr_host_model_i.wr(6'h17, {6'h00, prom[0], 1'b0});
      pfr_host_model_i.wr(6'h2e, {fvn[1:0], 1'b0, dis[0], 4'h0});
      RX_EXT_MODE = ext[0];
      RX_PHR_VALID = 1'b1;
      step();
      RX_PHR_VALID = 1'b0;
      check(8'(FRAME_START_IRQ), 8'(!ext || prom));
      for (int i = 0; i < n; i++)
      begin
         RX_BYTE_VALID = 1'b1;
         RX_BYTE = b[i];
         step();
      end
      RX_BYTE_VALID = 1'b0;
      RX_FRAME_DONE = 1'b1;
      RX_FCS_OK = fcs[0];
      step();
      RX_FRAME_DONE = 1'b0;
      RX_FCS_OK = !fcs[0];
      check(8'(FRAME_END_IRQ), 8'(!ext || prom || (fcs && m)));
      check(8'(ADDRESS_MATCH_IRQ), 8'(fcs && m));
      check(8'(ACK_START), 8'(ext && !dis && fcs && m && req && (fvn == 3 || ver <= fvn)));
      check(8'(RX_STATUS_BYTE[7]), 8'(fcs));
      pfr_host_model_i.read_status(d);
      check(d, {fcs[0], 2'b00, RX_SIGNAL_LEVEL});
   endtask

   initial
   begin
      CLK_SYS = 1'b0;
      forever #10 CLK_SYS = ~CLK_SYS;
   end

   // Hang guard sized well above the expected 3.7k cycles
   initial
   begin
      #500000;
      n_fail++;
      tally_and_finish();
   end

   initial
   begin
      {RST_B, RX_EXT_MODE, RX_PHR_VALID, RX_BYTE_VALID, RX_FRAME_DONE, RX_FCS_OK} = '0;
      RX_BYTE = 8'h00;
      seed = 97;
      RX_SIGNAL_LEVEL = 5'($random(seed));
      repeat (4) @(posedge CLK_SYS);
      #1;
      RST_B = 1'b1;
      repeat (2) step();
      // Reset values, one unmapped offset, and the read-only status
      pfr_host_model_i.wr(6'h06, 8'hff);
      for (int i = 0; i < 9; i++)
      begin
         pfr_host_model_i.rd(i < 8 ? 6'(i < 2 ? 'h17 + 'h17 * i : 'h1e + i) : 6'h3f, d);
         check(d, (i >= 2 && i <= 5) ? 8'hff : 8'h00);
      end
      pfr_host_model_i.read_status(d);
      check(d, {3'b000, RX_SIGNAL_LEVEL});
      $display("register test done");
      pfr_host_model_i.zero_addresses();
      pfr_host_model_i.rd(6'h20, d);
      check(d, 8'h00);
      my_short = 16'($random(seed));
      my_net = 16'($random(seed));
      pfr_host_model_i.wr(6'h20, my_short[7:0]);
      pfr_host_model_i.wr(6'h21, my_short[15:8]);
      pfr_host_model_i.wr(6'h22, my_net[7:0]);
      pfr_host_model_i.wr(6'h23, my_net[15:8]);
      my_ext = {$random(seed), $random(seed)};
      for (int i = 0; i < 8; i++)
         pfr_host_model_i.wr(6'(6'h24 + i), my_ext[8*i +: 8]);
      for (int i = 0; i < 200; i++)
      begin
         k = $random(seed);
         RX_SIGNAL_LEVEL = 5'(k >> 20);
         frame(k[0], k[1], k[2] & k[13], i % 4, k[4:3], k[5] | k[6], k[7] | k[8],
            k[10] ? (k[9] ? 'hffff : k[31:16]) : my_net,
            k[12] ? (k[11] ? 'hffff : k[27:12]) : my_short, k[14]);
      end
      $display("frame test done");
      // Mid-run reset must clear the FCS flag and the 0x17 mode register, and reload the short address
      RST_B = 1'b0;
      step();
      check(RX_STATUS_BYTE, 8'h00);
      RST_B = 1'b1;
      repeat (2) step();
      pfr_host_model_i.rd(6'h17, d);
      check(d, 8'h00);
      pfr_host_model_i.rd(6'h20, d);
      check(d, 8'hff);
      $display("reset test done");
      tally_and_finish();
   end
endmodule

bind pfr_rx_frame_filter pfr_rx_frame_filter_monitor pfr_rx_frame_filter_monitor_i (.CLK_SYS,
   .RST_B, .REG_ADDR, .REG_WDATA, .REG_WR, .RX_EXT_MODE, .RX_PHR_VALID, .RX_FRAME_DONE,
   .RX_FCS_OK, .FRAME_START_IRQ, .FRAME_END_IRQ, .ADDRESS_MATCH_IRQ, .ACK_START,
   .RX_STATUS_BYTE);
`default_nettype wire
